// *** sar_adc_serial_readout.sv ***
// Serial readout and conversion sequencing of the SAR converter
`timescale 1ns/1ps
`include "sar_readout_consts.svh"
module sar_adc_serial_readout (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic convert_strobe,
  input wire logic sdi,
  input wire logic [`DATA_W-1:0] adc_result,
  input wire logic overvoltage_in,
  input wire logic status_enable,
  input wire logic span_compression,
  input wire logic high_z_mode,
  input wire logic turbo_mode,
  output logic sdo,
  output logic sdo_oe,
  output logic converting,
  output logic chain_mode
);

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------
  // Timing
  // ----------------------------------------------------------
  // Longest conversion time, rounded down to whole cycles
  localparam int CONV_CYC = (`CONV_TIME_NS * `CLOCK_MHZ) / 1000;
  localparam logic [`TIMER_W-1:0] CONV_LAST =
    `TIMER_W'(CONV_CYC - 1);
  // Samples from the eighth high one to the one that sees the fall
  localparam int CONV_TAIL = CONV_CYC - 7;

  // ----------------------------------------------------------
  // Pin and link crossings
  // ----------------------------------------------------------
  logic cnv_s;
  logic sdi_s;
  logic cnv_q;
  logic sdi_q;
  logic [`CNT_W-1:0] gray_link;
  logic [`CNT_W-1:0] gray_s;
  logic [`CNT_W-1:0] cnt_bin;

  sck_fall_counter u_link_count (
    .sck(sck),
    .rst_n(rst_n),
    .gray_r(gray_link)
  );

  // Idle-high reset avoids a false strobe edge after release
  pin_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_cnv_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(convert_strobe),
    .value(cnv_s)
  );

  pin_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_sdi_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(sdi),
    .value(sdi_s)
  );

  pin_sync #(.WIDTH(`CNT_W), .RESET_VAL(`CNT_RESET)) u_cnt_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(gray_link),
    .value(gray_s)
  );

  function automatic logic [`CNT_W-1:0] gray_to_bin(
    input logic [`CNT_W-1:0] g
  );
    logic [`CNT_W-1:0] b;
    b = g;
    for (int i = `CNT_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  assign cnt_bin = gray_to_bin(gray_s);

  // ----------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------
  logic cnv_rise;
  logic cnv_fall;
  logic sdi_rise;
  logic sdi_fall;
  logic start_cs;
  logic start_chain;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnv_q <= 1'b1;
      sdi_q <= 1'b1;
    end else begin
      cnv_q <= cnv_s;
      sdi_q <= sdi_s;
    end
  end

  assign cnv_rise = cnv_s & ~cnv_q;
  assign cnv_fall = ~cnv_s & cnv_q;
  assign sdi_rise = sdi_s & ~sdi_q;
  assign sdi_fall = ~sdi_s & sdi_q;
  assign start_cs = cnv_rise & sdi_s;
  assign start_chain = cnv_rise & ~sdi_s;

  // ----------------------------------------------------------
  // Conversion sequencing
  // ----------------------------------------------------------
  sar_readout_pkg::conv_state_type conv_state_r;
  logic [`TIMER_W-1:0] timer_r;
  logic converting_r;
  logic conv_done_r;
  logic turbo_run_r;
  logic conv_end;
  logic chain_mode_r;

  assign conv_end = (conv_state_r == sar_readout_pkg::CONV_RUN) &&
                    (timer_r == CONV_LAST);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      conv_state_r <= sar_readout_pkg::CONV_IDLE;
      timer_r <= '0;
      converting_r <= 1'b0;
      conv_done_r <= 1'b0;
      turbo_run_r <= 1'b0;
    end else begin
      conv_done_r <= 1'b0;
      case (conv_state_r)
        sar_readout_pkg::CONV_IDLE: begin
          if (cnv_rise) begin
            conv_state_r <= sar_readout_pkg::CONV_RUN;
            timer_r <= '0;
            converting_r <= 1'b1;
            // Turbo has no meaning in chain operation
            turbo_run_r <= turbo_mode & sdi_s;
          end
        end
        sar_readout_pkg::CONV_RUN: begin
          // Strobe level is not looked at until the end
          if (conv_end) begin
            conv_state_r <= sar_readout_pkg::CONV_IDLE;
            converting_r <= 1'b0;
            conv_done_r <= 1'b1;
          end else begin
            timer_r <= timer_r + `TIMER_W'(1);
          end
        end
        default: begin
          conv_state_r <= sar_readout_pkg::CONV_IDLE;
          converting_r <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      chain_mode_r <= 1'b0;
    end else if (start_cs) begin
      chain_mode_r <= 1'b0;
    end else if (start_chain) begin
      chain_mode_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------
  // Result and status capture
  // ----------------------------------------------------------
  logic [`DATA_W-1:0] result_r;
  logic ov_n_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      result_r <= '0;
      ov_n_r <= 1'b1;
    end else if (conv_end) begin
      result_r <= adc_result;
      ov_n_r <= ~overvoltage_in;
    end
  end

  // Status bits sit right behind the data, overvoltage first
  function automatic logic [`WORD_W-1:0] build_word(
    input logic [`DATA_W-1:0] res,
    input logic ovn
  );
    return {res, ovn, span_compression, high_z_mode, turbo_mode,
            `STATUS_RSVD};
  endfunction

  // ----------------------------------------------------------
  // Readout frame
  // ----------------------------------------------------------
  sar_readout_pkg::read_state_type rd_state_r;
  logic [`WORD_W-1:0] word_r;
  logic [`CNT_W-1:0] base_r;
  logic [`CNT_W-1:0] frame_len_r;
  logic busy_r;
  logic wire4_r;
  logic sdo_r;
  logic sdo_oe_r;
  logic [`CNT_W-1:0] idx;
  logic [`CNT_W-1:0] pos;
  logic [`CNT_W-1:0] last_idx;
  logic [`CNT_W-1:0] word_idx;
  logic [`CNT_W-1:0] frame_len_nxt;
  logic shift_bit;
  logic frame_over;

  assign idx = cnt_bin - base_r;
  assign pos = idx - {5'h00, busy_r};
  assign last_idx = frame_len_r + {5'h00, busy_r};
  assign word_idx = `WORD_TOP - pos;
  assign frame_len_nxt = status_enable ? `FRAME_BITS : `DATA_BITS;
  // Busy start bit is a driven low before the MSB
  assign shift_bit = (busy_r && idx == `CNT_RESET) ? 1'b0 :
                     word_r[word_idx[4:0]];
  // Early stop by the host leaves the rest unsent
  assign frame_over = (wire4_r && sdi_rise) || (idx >= last_idx);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_state_r <= sar_readout_pkg::RD_IDLE;
      word_r <= '0;
      base_r <= `CNT_RESET;
      frame_len_r <= `DATA_BITS;
      busy_r <= 1'b0;
      wire4_r <= 1'b0;
      sdo_r <= 1'b0;
      sdo_oe_r <= 1'b0;
    end else if (cnv_rise) begin
      // New conversion ends any frame and floats the line
      sdo_oe_r <= 1'b0;
      sdo_r <= 1'b0;
      busy_r <= 1'b0;
      if (sdi_s && turbo_mode) begin
        // Previous result is offered during the conversion
        rd_state_r <= sar_readout_pkg::RD_ARMED;
        word_r <= build_word(result_r, ov_n_r);
        frame_len_r <= frame_len_nxt;
      end else begin
        rd_state_r <= sar_readout_pkg::RD_IDLE;
      end
    end else begin
      case (rd_state_r)
        sar_readout_pkg::RD_IDLE: begin
          // Turbo replaces the busy indicator in both wirings
          if (conv_done_r && !turbo_run_r && !chain_mode_r) begin
            word_r <= build_word(result_r, ov_n_r);
            frame_len_r <= frame_len_nxt;
            if (!cnv_s || !sdi_s) begin
              busy_r <= 1'b1;
              wire4_r <= cnv_s;
              base_r <= cnt_bin;
              sdo_oe_r <= 1'b1;
              sdo_r <= 1'b0;
              rd_state_r <= sar_readout_pkg::RD_SHIFT;
            end else begin
              busy_r <= 1'b0;
              rd_state_r <= sar_readout_pkg::RD_ARMED;
            end
          end
        end
        sar_readout_pkg::RD_ARMED: begin
          if (cnv_fall || (cnv_s && sdi_fall)) begin
            wire4_r <= cnv_s;
            base_r <= cnt_bin;
            sdo_oe_r <= 1'b1;
            sdo_r <= word_r[`WORD_MSB];
            rd_state_r <= sar_readout_pkg::RD_SHIFT;
          end
        end
        sar_readout_pkg::RD_SHIFT: begin
          if (frame_over) begin
            sdo_oe_r <= 1'b0;
            busy_r <= 1'b0;
            rd_state_r <= sar_readout_pkg::RD_IDLE;
          end else begin
            // Bit changes only after a falling edge
            sdo_r <= shift_bit;
          end
        end
        default: begin
          sdo_oe_r <= 1'b0;
          rd_state_r <= sar_readout_pkg::RD_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------
  assign sdo = sdo_r;
  assign sdo_oe = sdo_oe_r;
  assign converting = converting_r;
  assign chain_mode = chain_mode_r;

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  sequence s_armed_quiet;
    rd_state_r == sar_readout_pkg::RD_ARMED && !cnv_rise;
  endsequence

  sequence s_strobe_drop;
    cnv_fall;
  endsequence

  sequence s_sdi_drop;
    cnv_s && sdi_fall;
  endsequence

  sequence s_shift_live;
    rd_state_r == sar_readout_pkg::RD_SHIFT && !cnv_rise;
  endsequence

  a_start_floats: assert property (
    start_cs |=> !sdo_oe_r && !chain_mode_r
  ) else $error("start with SDI high did not float SDO");

  a_chain_select: assert property (
    start_chain |=> chain_mode_r && !sdo_oe_r
  ) else $error("start with SDI low did not select chain");

  a_conv_length: assert property (
    $rose(converting_r) |-> converting_r[*8] ##CONV_TAIL
      $fell(converting_r)
  ) else $error("conversion length wrong");

  a_power_down: assert property (
    $rose(conv_done_r) |-> !converting_r && $past(conv_end)
  ) else $error("converter still powered after conversion");

  a_ov_refresh: assert property (
    $rose(conv_done_r) |-> ov_n_r == !$past(overvoltage_in)
  ) else $error("overvoltage bit not refreshed");

  a_msb_on_fall: assert property (
    s_armed_quiet ##0 s_strobe_drop |=>
      sdo_oe_r && sdo_r == word_r[`WORD_MSB] && !wire4_r
  ) else $error("strobe fall did not show MSB");

  a_msb_on_sdi: assert property (
    s_armed_quiet ##0 s_sdi_drop |=>
      sdo_oe_r && sdo_r == word_r[`WORD_MSB] && wire4_r
  ) else $error("SDI fall did not show MSB");

  a_frame_end: assert property (
    s_shift_live ##0 (idx >= last_idx) |=> !sdo_oe_r
  ) else $error("SDO still driven after last bit");

  a_frame_hold: assert property (
    s_shift_live ##0 !frame_over |=> sdo_oe_r
  ) else $error("SDO floated inside a frame");

  a_busy_low: assert property (
    rd_state_r == sar_readout_pkg::RD_IDLE && conv_done_r &&
      !turbo_run_r && !chain_mode_r && !cnv_s && !cnv_rise |=>
      sdo_oe_r && !sdo_r && busy_r
  ) else $error("busy indicator not driven low");

  a_turbo_arm: assert property (
    start_cs && turbo_mode |=>
      rd_state_r == sar_readout_pkg::RD_ARMED &&
      word_r[`WORD_W-1:`WORD_W-`DATA_W] == $past(result_r)
  ) else $error("turbo did not offer previous result");

endmodule

// *** sar_readout_consts.svh ***
// Constants for the serial readout logic of the 16-bit converter
// Summary of operation
// - Enabled status word follows the conversion result
// - Status bits: overvoltage, span, high-Z, turbo, reserved
// - Overvoltage bit low means overvoltage; per conversion
// - Output floats after the last status bit
// - Turbo bit replaces the busy-indicator variant
// - Turbo rising strobe converts, offers previous result
// - 3-wire: strobe fall shows MSB, SCK falls shift
// - 3-wire: float at 16th fall (22nd with status) or strobe rise
// - 4-wire turbo: SDI low reads, SDI rise floats
// - Started conversion ignores later strobe levels
// - Busy mode: drive after conversion, 17 falls (23 with status)
// - After conversion, acquire and power down converter
// - Output bit valid across both SCK edges
// - SDI high strobe rise: convert, select, float
// - SDI at strobe rise selects chip-select or chain
// - Turbo replaces busy indicator in both wirings
`ifndef SAR_READOUT_CONSTS_SVH
`define SAR_READOUT_CONSTS_SVH

// ----------------------------------------------------------
// Timing
// ----------------------------------------------------------
`define CLOCK_MHZ 125
`define CONV_TIME_NS 320
`define TIMER_W 8

// ----------------------------------------------------------
// Frame layout
// ----------------------------------------------------------
`define CNT_W 6
`define WORD_W 22
`define DATA_W 16
`define DATA_BITS 6'h10
`define FRAME_BITS 6'h16
`define WORD_TOP 6'h15
`define WORD_MSB 5'h15
`define STATUS_RSVD 2'h0
`define CNT_RESET 6'h00

`endif

// *** sar_readout_pkg.sv ***
// Types shared by the serial readout logic
package sar_readout_pkg;

  typedef enum logic {CONV_IDLE, CONV_RUN} conv_state_type;

  typedef enum logic [1:0] {RD_IDLE, RD_ARMED, RD_SHIFT} read_state_type;

endpackage

// *** pin_sync.sv ***
// Three-stage synchroniser that accepts a value once stages agree
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] value
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] mid_r;
  logic [WIDTH-1:0] last_r;
  logic [WIDTH-1:0] held_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RESET_VAL;
      mid_r <= RESET_VAL;
      last_r <= RESET_VAL;
      held_r <= RESET_VAL;
    end else begin
      meta_r <= async_in;
      mid_r <= meta_r;
      last_r <= mid_r;
      held_r <= value;
    end
  end

  // Combinational pass saves a cycle of readout latency
  assign value = (mid_r == last_r) ? last_r : held_r;

endmodule

// *** sck_fall_counter.sv ***
// Falling-edge counter on the serial clock, gray coded for crossing
`timescale 1ns/1ps
`include "sar_readout_consts.svh"
module sck_fall_counter (
  input wire logic sck,
  input wire logic rst_n,
  output logic [`CNT_W-1:0] gray_r
);

  logic [`CNT_W-1:0] count_r;
  logic [`CNT_W-1:0] count_nxt;

  assign count_nxt = count_r + `CNT_W'(1);

  // Free running: only differences matter, so no frame reset needed
  always_ff @(negedge sck or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= `CNT_RESET;
      gray_r <= `CNT_RESET;
    end else begin
      count_r <= count_nxt;
      gray_r <= count_nxt ^ (count_nxt >> 1);
    end
  end

endmodule

// *** spi_host_model.sv ***
// Host side model: strobe, select line and serial clock of the readout
`timescale 1ns/1ps
module spi_host_model (
  input wire logic clock,
  input wire logic sdo_wire,
  output logic sck,
  output logic convert_strobe,
  output logic sdi
);
  initial begin
    sck = 1'b0;
    convert_strobe = 1'b1;
    sdi = 1'b1;
  end

  // ----------------------------------------
  // Pin tasks
  // ----------------------------------------
  // Strobe low long enough to pass the synchroniser, then rise
  task automatic pulse(input logic sel);
    @(negedge clock);
    convert_strobe = 1'b0;
    repeat (6) @(negedge clock);
    sdi = sel;
    repeat (6) @(negedge clock);
    convert_strobe = 1'b1;
  endtask

  // Three cycles high still pass the pin filter; drop lands early
  task automatic strobe_low();
    repeat (3) @(negedge clock);
    convert_strobe = 1'b0;
  endtask

  // Quiet gap before the select edge
  task automatic select(input logic four);
    repeat (10) @(negedge clock);
    if (four) begin
      sdi = 1'b0;
    end else begin
      convert_strobe = 1'b0;
    end
    repeat (10) @(negedge clock);
  endtask

  // Clock idles low outside frames
  // 80 ns period; full rate needs turbo and a faster clock
  task automatic shift(input int n, output logic [22:0] q);
    q = '0;
    #3;
    for (int i = 0; i < n; i++) begin
      #40 sck = 1'b1;
      #39 q = {q[21:0], sdo_wire};
      #1 sck = 1'b0;
    end
    #40;
  endtask

  // Gap after the last fall; strobe stays put, since its
  // next rise starts a conversion
  task automatic deselect();
    repeat (6) @(negedge clock);
    sdi = 1'b1;
  endtask
endmodule

// *** sar_adc_serial_readout_tb.sv ***
// Self-checking bench of the serial readout
`timescale 1ns/1ps
`include "sar_readout_consts.svh"
module sar_adc_serial_readout_tb;
  localparam int CONV_CYC = `CONV_TIME_NS * `CLOCK_MHZ / 1000;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [`DATA_W-1:0] adc_result;
  logic overvoltage_in;
  logic status_enable;
  logic span_compression;
  logic high_z_mode;
  logic turbo_mode;
  logic sck, convert_strobe, sdi, sdo, sdo_oe, converting, chain_mode;
  logic [22:0] q;
  logic [`DATA_W-1:0] prev;
  int nb;
  int n_mismatch = 0;
  int n_compared = 0;
  int seed = 67961;
  int cycles = 0;
  // Pull-up on the data line while nobody drives it
  wire sdo_wire = sdo_oe ? sdo : 1'b1;

  always #4 clock = ~clock;

  sar_adc_serial_readout sar_adc_serial_readout_inst (
    .clock(clock), .rst_n(rst_n), .sck(sck),
    .convert_strobe(convert_strobe), .sdi(sdi),
    .adc_result(adc_result), .overvoltage_in(overvoltage_in),
    .status_enable(status_enable), .span_compression(span_compression),
    .high_z_mode(high_z_mode), .turbo_mode(turbo_mode), .sdo(sdo),
    .sdo_oe(sdo_oe), .converting(converting), .chain_mode(chain_mode)
  );

  spi_host_model spi_host_model_inst (
    .clock(clock), .sdo_wire(sdo_wire), .sck(sck),
    .convert_strobe(convert_strobe), .sdi(sdi)
  );

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [22:0] seen,
                       input logic [22:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      conclude();
    end
  end

  // Frame bits expected for n falls, status word after the result
  function automatic logic [22:0] frame(input logic [15:0] r, input int n);
    logic [21:0] w;
    w = {r, ~overvoltage_in, span_compression, high_z_mode, turbo_mode,
         2'b00};
    return 23'(w >> (22 - n));
  endfunction

  // Waits for a conversion; output stays floating meanwhile
  task automatic convert(input logic count_it);
    int i;
    int c;
    logic bad;
    i = 0;
    c = 0;
    bad = 1'b0;
    while (converting !== 1'b1 && i < 20) begin
      @(posedge clock);
      #1 i++;
    end
    while (converting === 1'b1 && c < 100) begin
      if (sdo_oe !== 1'b0) bad = 1'b1;
      @(posedge clock);
      #1 c++;
    end
    if (count_it) check("conv_cycles", 23'(c), 23'(CONV_CYC));
    check("float_in_conv", 23'(bad), 23'h0);
    check("powered_down", 23'(converting), 23'h0);
  endtask

  task automatic randomize_inputs();
    @(negedge clock);
    adc_result = 16'($random(seed));
    overvoltage_in = 1'($random(seed));
    span_compression = 1'($random(seed));
    high_z_mode = 1'($random(seed));
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    turbo_mode = 1'b0;
    check("reset_outs", 23'({sdo_oe, converting, chain_mode}), 23'h0);
    // Plain 3-wire reads, with and without status word
    for (int k = 0; k < 6; k++) begin
      randomize_inputs();
      status_enable = k[0];
      spi_host_model_inst.pulse(1'b1);
      convert(1'b1);
      spi_host_model_inst.select(1'b0);
      spi_host_model_inst.shift(k[0] ? 22 : 16, q);
      check("read_3w", q, frame(adc_result, k[0] ? 22 : 16));
      check("float_end", 23'(sdo_oe), 23'h0);
      spi_host_model_inst.deselect();
    end
    // Early stop in the status word, strobe rise ends frame
    spi_host_model_inst.pulse(1'b1);
    convert(1'b0);
    spi_host_model_inst.select(1'b0);
    spi_host_model_inst.shift(18, q);
    check("read_part", q, frame(adc_result, 18));
    spi_host_model_inst.deselect();
    check("part_open", 23'(sdo_oe), 23'h1);
    spi_host_model_inst.pulse(1'b1);
    repeat (8) @(negedge clock);
    check("abort_float", 23'(sdo_oe), 23'h0);
    convert(1'b0);
    // Busy indicator: strobe back low during conversion
    status_enable = 1'b0;
    randomize_inputs();
    spi_host_model_inst.pulse(1'b1);
    spi_host_model_inst.strobe_low();
    convert(1'b1);
    repeat (6) @(negedge clock);
    check("busy_start", 23'({sdo_oe, sdo_wire}), 23'h2);
    spi_host_model_inst.shift(17, q);
    check("read_busy", q, frame(adc_result, 16));
    check("busy_float", 23'(sdo_oe), 23'h0);
    spi_host_model_inst.deselect();
    // Chain selection by low SDI, then back to chip-select
    spi_host_model_inst.pulse(1'b0);
    convert(1'b0);
    check("chain_on", 23'({chain_mode, sdo_oe}), 23'h2);
    spi_host_model_inst.pulse(1'b1);
    convert(1'b0);
    check("chain_off", 23'(chain_mode), 23'h0);
    // Turbo reads of the previous result, 3-wire then 4-wire
    for (int w = 0; w < 2; w++) begin
      randomize_inputs();
      turbo_mode = 1'b1;
      status_enable = w[0];
      nb = w[0] ? 22 : 16;
      prev = adc_result;
      spi_host_model_inst.pulse(1'b1);
      convert(1'b0);
      spi_host_model_inst.pulse(1'b1);
      adc_result = 16'($random(seed));
      spi_host_model_inst.select(w[0]);
      spi_host_model_inst.shift(nb, q);
      check("turbo_prev", q, frame(prev, nb));
      check("turbo_float", 23'(sdo_oe), 23'h0);
      spi_host_model_inst.deselect();
      repeat (8) @(negedge clock);
      check("turbo_nobusy", 23'({converting, sdo_oe}), 23'h0);
    end
    conclude();
  end
endmodule
